// [src/branch_and_load_execute.sv]
// Execution slice: flag branches, register moves and indirect data loads
`default_nettype none

// Summary of operation
// - Carry clear branches to counter plus offset plus one
// - Carry set branches; flags untouched
// - Negative set redirects counter
// - Negative clear redirects counter; no flag change
// - N xor V zero takes signed-ge branch
// - N xor V one takes signed-less branch
// - Half-carry set takes branch
// - Half-carry clear takes branch
// - User bit set takes branch
// - Interrupt enable set takes branch
// - Interrupt enable clear takes branch; flags unchanged
// - Register copy in one cycle, no flags
// - Post-increment load reads then bumps pointer
// - Pre-decrement load decrements then reads
// - Displacement load, pointer unchanged, two cycles
module branch_and_load_execute
  import exec_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        instr_valid,
  input  wire exec_pkg::op_t               op,
  input  wire exec_pkg::addr_mode_t        addr_mode,
  input  wire logic [1:0]                  ptr_sel,
  input  wire logic [4:0]                  dest_idx,
  input  wire logic [4:0]                  source_register,
  input  wire logic [6:0]                  branch_offset,
  input  wire logic [7:0]                  imm_value,
  input  wire logic [5:0]                  disp_value,
  input  wire logic [7:0]                  status_flags,
  input  wire logic [7:0]                  mem_rd_data,
  output logic                             instr_ready,
  output logic      [PC_W-1:0]             program_counter,
  output logic                             mem_rd_en,
  output logic      [ADDR_W-1:0]           mem_addr,
  output logic      [REG_COUNT*REG_W-1:0]  regs_q
);
  import exec_pkg::*;

  typedef enum logic [1:0] {st_idle, st_branch, st_load} state_t;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic branch_cond(input op_t o, input logic [7:0] f);
    case (o)
      branch_unsigned_ge:      branch_cond = !f[FLAG_C];
      branch_unsigned_less:    branch_cond = f[FLAG_C];
      branch_negative:         branch_cond = f[FLAG_N];
      branch_non_negative:     branch_cond = !f[FLAG_N];
      branch_signed_ge:        branch_cond = !(f[FLAG_N] ^ f[FLAG_V]);
      branch_signed_less:      branch_cond = f[FLAG_N] ^ f[FLAG_V];
      branch_half_carry_set:   branch_cond = f[FLAG_H];
      branch_half_carry_clear: branch_cond = !f[FLAG_H];
      branch_user_bit_set:     branch_cond = f[FLAG_T];
      branch_irq_on:           branch_cond = f[FLAG_I];
      branch_irq_off:          branch_cond = !f[FLAG_I];
      default:                 branch_cond = 1'b0;
    endcase
  endfunction

  function automatic logic is_branch(input op_t o);
    is_branch = (o >= branch_unsigned_ge) && (o <= branch_irq_off);
  endfunction

  function automatic logic [3:0] ptr_pair(input logic [1:0] sel);
    case (sel)
      2'h0:    ptr_pair = PAIR_PTR_X;
      2'h1:    ptr_pair = PAIR_PTR_Y;
      default: ptr_pair = PAIR_PTR_Z;
    endcase
  endfunction

  function automatic logic [7:0] reg_at(input logic [REG_COUNT*REG_W-1:0] r,
                                         input logic [4:0] i);
    reg_at = r[i*REG_W +: REG_W];
  endfunction

  // Low byte sits in the even register
  function automatic logic [15:0] pair_at(input logic [REG_COUNT*REG_W-1:0] r,
                                           input logic [3:0] p);
    pair_at = r[p*2*REG_W +: 2*REG_W];
  endfunction

  // ----------------------------------------------------------------
  // Accept and next-value computation
  // ----------------------------------------------------------------
  state_t            state_reg;
  logic              accept;
  logic              taken;
  logic [PC_W-1:0]   pc_next;
  logic [3:0]        ptr_idx;
  logic [15:0]       ptr_val;
  logic [15:0]       load_addr;
  logic [15:0]       ptr_new;
  logic              ptr_wr;
  logic [4:0]        load_dest_reg;
  logic              wr_en;
  logic [4:0]        wr_idx;
  logic [7:0]        wr_data;
  logic              pair_wr_en;
  logic [3:0]        pair_idx;
  logic [15:0]       pair_data;

  assign accept  = instr_valid && instr_ready;
  assign taken   = is_branch(op) && branch_cond(op, status_flags);
  assign ptr_idx = ptr_pair(ptr_sel);
  assign ptr_val = pair_at(regs_q, ptr_idx);

  // Offset is a signed word displacement relative to the next instruction
  assign pc_next = taken ? program_counter + PC_W'($signed(branch_offset)) + PC_W'(1)
                         : program_counter + PC_W'(1);

  always_comb begin
    load_addr = ptr_val;
    ptr_new   = ptr_val;
    ptr_wr    = 1'b0;
    if (op == load_offset) begin
      load_addr = ptr_val + 16'(disp_value);
    end else if (addr_mode == addr_post_inc) begin
      ptr_new = ptr_val + 16'h0001;
      ptr_wr  = 1'b1;
    end else if (addr_mode == addr_pre_dec) begin
      ptr_new   = ptr_val - 16'h0001;
      load_addr = ptr_new;
      ptr_wr    = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register file write steering; moves and constants land at accept
  // ----------------------------------------------------------------
  always_comb begin
    wr_en      = 1'b0;
    wr_idx     = dest_idx;
    wr_data    = imm_value;
    pair_wr_en = 1'b0;
    pair_idx   = dest_idx[4:1];
    pair_data  = pair_at(regs_q, source_register[4:1]);
    if (state_reg == st_load) begin
      wr_en   = 1'b1;
      wr_idx  = load_dest_reg;
      wr_data = mem_rd_data;
    end else if (accept) begin
      case (op)
        register_copy: begin
          wr_en   = 1'b1;
          wr_data = reg_at(regs_q, source_register);
        end
        copy_register_pair: pair_wr_en = 1'b1;
        load_constant:      wr_en = 1'b1;
        load_indirect: begin
          pair_wr_en = ptr_wr;
          pair_idx   = ptr_idx;
          pair_data  = ptr_new;
        end
        default: wr_en = 1'b0;
      endcase
    end
  end

  work_regs u_regs (
    .clk        (clk),
    .rst_b      (rst_b),
    .wr_en      (wr_en),
    .wr_idx     (wr_idx),
    .wr_data    (wr_data),
    .pair_wr_en (pair_wr_en),
    .pair_idx   (pair_idx),
    .pair_data  (pair_data),
    .regs_q     (regs_q)
  );

  // ----------------------------------------------------------------
  // Sequencer: a taken branch or a load holds off the next instruction
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= st_idle;
      instr_ready <= 1'b1;
    end else begin
      case (state_reg)
        st_idle: begin
          if (accept && taken) begin
            state_reg   <= st_branch;
            instr_ready <= 1'b0;
          end else if (accept && (op == load_indirect || op == load_offset)) begin
            state_reg   <= st_load;
            instr_ready <= 1'b0;
          end
        end
        default: begin
          state_reg   <= st_idle;
          instr_ready <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      program_counter <= PC_W'(PC_RESET);
    end else if (accept) begin
      program_counter <= pc_next;
    end
  end

  // Memory read data must be valid while the read strobe is high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_rd_en     <= 1'b0;
      mem_addr      <= '0;
      load_dest_reg <= '0;
    end else if (accept && (op == load_indirect || op == load_offset)) begin
      mem_rd_en     <= 1'b1;
      mem_addr      <= load_addr;
      load_dest_reg <= dest_idx;
    end else begin
      mem_rd_en <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] ptr_seen_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_seen_reg <= '0;
    end else if (accept) begin
      ptr_seen_reg <= ptr_val;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_load_accept;
    accept && (op == load_indirect || op == load_offset);
  endsequence
  sequence s_load_finish;
    mem_rd_en && !instr_ready ##1 !mem_rd_en && instr_ready;
  endsequence

  chk_branch_skip: assert property (
    accept && is_branch(op) && !taken |=> instr_ready
      && program_counter == $past(program_counter) + PC_W'(1))
    else $error("skipped branch not one cycle to next word");
  chk_branch_target: assert property (
    accept && taken |=> program_counter == $past(program_counter)
      + PC_W'($signed($past(branch_offset))) + PC_W'(1))
    else $error("taken branch target wrong");
  chk_branch_stall: assert property (
    accept && taken |=> !instr_ready ##1 instr_ready)
    else $error("taken branch not two cycles");
  chk_load_timing: assert property (
    s_load_accept |=> s_load_finish)
    else $error("load not two cycles");
  chk_post_inc_ptr: assert property (
    accept && op == load_indirect && addr_mode == addr_post_inc
      |=> mem_addr == ptr_seen_reg && pair_at(regs_q, $past(ptr_idx)) == ptr_seen_reg + 16'h0001)
    else $error("post-increment load wrong");
  chk_pre_dec_ptr: assert property (
    accept && op == load_indirect && addr_mode == addr_pre_dec
      |=> mem_addr == ptr_seen_reg - 16'h0001 && pair_at(regs_q, $past(ptr_idx)) == mem_addr)
    else $error("pre-decrement load wrong");
  chk_disp_addr: assert property (
    accept && op == load_offset
      |=> mem_addr == ptr_seen_reg + 16'($past(disp_value))
      && pair_at(regs_q, $past(ptr_idx)) == ptr_seen_reg)
    else $error("displacement load wrong");
  chk_load_dest: assert property (
    mem_rd_en |=> reg_at(regs_q, $past(load_dest_reg)) == $past(mem_rd_data))
    else $error("loaded byte not written");
  chk_copy_move: assert property (
    accept && op == register_copy && source_register != dest_idx
      |=> instr_ready && reg_at(regs_q, $past(dest_idx)) == $past(reg_at(regs_q, source_register)))
    else $error("register copy wrong");
  chk_pair_move: assert property (
    accept && op == copy_register_pair
      |=> instr_ready && pair_at(regs_q, $past(dest_idx[4:1]))
      == $past(pair_at(regs_q, source_register[4:1])))
    else $error("pair copy wrong");
  chk_const_load: assert property (
    accept && op == load_constant
      |=> instr_ready && reg_at(regs_q, $past(dest_idx)) == $past(imm_value))
    else $error("constant load wrong");

endmodule // branch_and_load_execute
`default_nettype wire

// [src/exec_pkg.sv]
// Package: opcodes, flag positions, pointer pairs, reset values and cycle counts of the slice
`default_nettype none
package exec_pkg;

  // ----------------------------------------------------------------
  // Operations handled by this slice
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    op_nop,
    branch_unsigned_ge,
    branch_unsigned_less,
    branch_negative,
    branch_non_negative,
    branch_signed_ge,
    branch_signed_less,
    branch_half_carry_set,
    branch_half_carry_clear,
    branch_user_bit_set,
    branch_irq_on,
    branch_irq_off,
    register_copy,
    copy_register_pair,
    load_constant,
    load_indirect,
    load_offset
  } op_t;

  typedef enum logic [1:0] {
    addr_plain,
    addr_post_inc,
    addr_pre_dec
  } addr_mode_t;

  // ----------------------------------------------------------------
  // Status flag bit positions
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ----------------------------------------------------------------
  // Register file and pointer pairs (pair index = low register / 2)
  // ----------------------------------------------------------------
  localparam int          REG_COUNT  = 32;
  localparam int          REG_W      = 8;
  localparam int          ADDR_W     = 16;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [3:0]  PAIR_PTR_X = 4'hD;
  localparam logic [3:0]  PAIR_PTR_Y = 4'hE;
  localparam logic [3:0]  PAIR_PTR_Z = 4'hF;
  localparam logic [15:0] PC_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int BRANCH_SKIP_CYCLES  = 1;
  localparam int BRANCH_TAKEN_CYCLES = 2;
  localparam int MOVE_CYCLES         = 1;
  localparam int LOAD_CYCLES         = 2;

endpackage : exec_pkg
`default_nettype wire

// [src/work_regs.sv]
// Working register file: 32 bytes with a byte write port and a pair write port
`default_nettype none
module work_regs
  import exec_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        wr_en,
  input  wire logic [4:0]                  wr_idx,
  input  wire logic [REG_W-1:0]            wr_data,
  input  wire logic                        pair_wr_en,
  input  wire logic [3:0]                  pair_idx,
  input  wire logic [2*REG_W-1:0]          pair_data,
  output logic      [REG_COUNT*REG_W-1:0]  regs_q
);

  // ----------------------------------------------------------------
  // One flop byte per register; pair write wins over a byte write
  // ----------------------------------------------------------------
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        regs_q[g*REG_W +: REG_W] <= REG_RESET;
      end else if (pair_wr_en && pair_idx == 4'(g / 2)) begin
        regs_q[g*REG_W +: REG_W] <= pair_data[(g % 2)*REG_W +: REG_W];
      end else if (wr_en && wr_idx == 5'(g)) begin
        regs_q[g*REG_W +: REG_W] <= wr_data;
      end
    end
  end

endmodule // work_regs
`default_nettype wire

// [dv/test_branch_and_load_execute.sv]
// Self-checking bench for the branch, move and indirect load execution slice
`default_nettype none
module test_branch_and_load_execute;
  timeunit 1ns;
  timeprecision 100ps;
  import exec_pkg::*;

  logic                       clk;
  logic                       rst_b;
  logic                       instr_valid;
  op_t                        op;
  addr_mode_t                 addr_mode;
  logic [1:0]                 ptr_sel;
  logic [4:0]                 dest_idx;
  logic [4:0]                 source_register;
  logic [6:0]                 branch_offset;
  logic [7:0]                 imm_value;
  logic [5:0]                 disp_value;
  logic [7:0]                 status_flags;
  logic [7:0]                 mem_rd_data;
  logic                       instr_ready;
  logic [15:0]                program_counter;
  logic                       mem_rd_en;
  logic [ADDR_W-1:0]          mem_addr;
  logic [REG_COUNT*REG_W-1:0] regs_q;
  logic [7:0]                 rm [32];
  logic [15:0]                pcm;
  int                         err_count;
  int                         num_checks;
  int                         cyc = 0;

  branch_and_load_execute #(.PC_W(16)) u_dut (
    .clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .op(op), .addr_mode(addr_mode),
    .ptr_sel(ptr_sel), .dest_idx(dest_idx), .source_register(source_register),
    .branch_offset(branch_offset), .imm_value(imm_value), .disp_value(disp_value),
    .status_flags(status_flags), .mem_rd_data(mem_rd_data), .instr_ready(instr_ready),
    .program_counter(program_counter), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
    .regs_q(regs_q)
  );

  // ----------------------------------------------------------------
  // Clock, data memory and hang guard
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;

  function automatic logic [7:0] mdat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  // Memory answers combinationally from the registered address
  assign mem_rd_data = mdat(mem_addr);

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] rb(input logic [4:0] i);
    return regs_q[8*i +: 8];
  endfunction

  function automatic logic taken(input op_t o, input logic [7:0] f);
    case (o)
      branch_unsigned_ge:      return !f[FLAG_C];
      branch_unsigned_less:    return f[FLAG_C];
      branch_negative:         return f[FLAG_N];
      branch_non_negative:     return !f[FLAG_N];
      branch_signed_ge:        return !(f[FLAG_N] ^ f[FLAG_V]);
      branch_signed_less:      return f[FLAG_N] ^ f[FLAG_V];
      branch_half_carry_set:   return f[FLAG_H];
      branch_half_carry_clear: return !f[FLAG_H];
      branch_user_bit_set:     return f[FLAG_T];
      branch_irq_on:           return f[FLAG_I];
      branch_irq_off:          return !f[FLAG_I];
      default:                 return 1'b0;
    endcase
  endfunction

  // One instruction; returns at the settled middle of the cycle after acceptance
  task automatic go(input op_t o, input addr_mode_t m, input logic [1:0] p,
                    input logic [4:0] d, input logic [4:0] s, input logic [6:0] k,
                    input logic [7:0] imm, input logic [5:0] q, input logic [7:0] f);
    logic tk;
    tk = taken(o, f);
    @(posedge clk);
    op <= o;
    addr_mode <= m;
    ptr_sel <= p;
    dest_idx <= d;
    source_register <= s;
    branch_offset <= k;
    imm_value <= imm;
    disp_value <= q;
    status_flags <= f;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    pcm = pcm + 16'h0001 + (tk ? {{9{k[6]}}, k} : 16'h0000);
    check(program_counter, pcm);
    check(instr_ready, !(tk || o == load_indirect || o == load_offset));
  endtask

  task automatic ldc(input logic [4:0] d, input logic [7:0] v);
    go(load_constant, addr_plain, 2'h0, d, 5'h00, 7'h00, v, 6'h00, 8'h00);
    rm[d] = v;
    check(rb(d), v);
  endtask

  task automatic ld(input op_t o, input addr_mode_t m, input logic [1:0] p,
                    input logic [4:0] d, input logic [5:0] q);
    logic [4:0]  lo;
    logic [15:0] ptr;
    logic [15:0] a;
    lo = (p == 2'h0) ? 5'h1A : (p == 2'h1) ? 5'h1C : 5'h1E;
    ptr = {rm[5'(lo + 1)], rm[lo]};
    a = (o == load_offset) ? ptr + {10'h000, q} : (m == addr_pre_dec) ? ptr - 16'h0001 : ptr;
    if (o == load_indirect && m == addr_post_inc) ptr = ptr + 16'h0001;
    else if (o == load_indirect && m == addr_pre_dec) ptr = a;
    go(o, m, p, d, 5'h00, 7'h00, 8'h00, q, 8'hFF);
    check(mem_rd_en, 1'b1);
    check(mem_addr, a);
    check({rb(5'(lo + 1)), rb(lo)}, ptr);
    {rm[5'(lo + 1)], rm[lo]} = ptr;
    rm[d] = mdat(a);
    @(negedge clk);
    check(mem_rd_en, 1'b0);
    check(rb(d), rm[d]);
    check(instr_ready, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic branch_table();
    logic [7:0] pats [4];
    pats = '{8'hFF, 8'h00, 8'h04, 8'h08};
    for (int i = int'(branch_unsigned_ge); i <= int'(branch_irq_off); i++) begin
      for (int j = 0; j < 4; j++) begin
        go(op_t'(i), addr_plain, 2'h0, 5'h00, 5'h00, j[0] ? 7'h40 : 7'h3F, 8'h00, 6'h00, pats[j]);
        check(program_counter, pcm);
        check(program_counter, pcm);
        @(negedge clk);
        check(instr_ready, 1'b1);
      end
    end
  endtask

  // Taken branch then a held request: the idle cycle must refuse it
  task automatic refuse_and_b2b();
    @(posedge clk);
    op <= branch_negative;
    branch_offset <= 7'h05;
    status_flags <= 8'h04;
    instr_valid <= 1'b1;
    @(posedge clk);
    op <= op_nop;
    repeat (3) @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    pcm = pcm + 16'h0008;
    check(program_counter, pcm);
  endtask

  task automatic moves();
    ldc(5'h1A, 8'h3C);
    ldc(5'h1B, 8'hA1);
    ldc(5'h09, 8'h77);
    go(register_copy, addr_plain, 2'h0, 5'h09, 5'h1A, 7'h00, 8'h00, 6'h00, 8'h00);
    check(rb(5'h09), 8'h3C);
    check(rb(5'h1A), 8'h3C);
    go(copy_register_pair, addr_plain, 2'h0, 5'h02, 5'h1A, 7'h00, 8'h00, 6'h00, 8'h00);
    check({rb(5'h03), rb(5'h02)}, 16'hA13C);
  endtask

  task automatic loads();
    ldc(5'h1A, 8'h00);
    ldc(5'h1B, 8'h00);
    ld(load_indirect, addr_pre_dec, 2'h0, 5'h04, 6'h00);
    ld(load_indirect, addr_post_inc, 2'h0, 5'h05, 6'h00);
    ld(load_indirect, addr_plain, 2'h0, 5'h06, 6'h00);
    ldc(5'h1C, 8'hFF);
    ldc(5'h1D, 8'h12);
    ld(load_indirect, addr_post_inc, 2'h1, 5'h07, 6'h00);
    ld(load_offset, addr_plain, 2'h1, 5'h08, 6'h3F);
    ldc(5'h1E, 8'h01);
    ldc(5'h1F, 8'h80);
    ld(load_indirect, addr_pre_dec, 2'h2, 5'h0A, 6'h00);
    ld(load_offset, addr_plain, 2'h3, 5'h0B, 6'h00);
    ld(load_indirect, addr_post_inc, 2'h3, 5'h0C, 6'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    instr_valid = 1'b0;
    op = op_nop;
    addr_mode = addr_plain;
    ptr_sel = 2'h0;
    dest_idx = 5'h00;
    source_register = 5'h00;
    branch_offset = 7'h00;
    imm_value = 8'h00;
    disp_value = 6'h00;
    status_flags = 8'h00;
    err_count = 0;
    num_checks = 0;
    pcm = PC_RESET;
    foreach (rm[i]) rm[i] = REG_RESET;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check(program_counter, PC_RESET);
    branch_table();
    refuse_and_b2b();
    moves();
    loads();
    finish_test();
  end

endmodule // test_branch_and_load_execute
`default_nettype wire
